// ### mcb_async_fifo.v
// Purpose: Dual-clock FIFO with gray-coded pointer crossing.
// Assumes: Depth is 2**AW; each side has its own synchronised reset.
// Notes:   Stall and empty flags are registered; read data is show-ahead.
`timescale 1ns/1ps
`default_nettype none

module mcb_async_fifo #(
  parameter W  = 8,
  parameter AW = 2
) (
  input  wire          wr_clk,
  input  wire          wr_rst_n,
  input  wire          wr_push,
  input  wire [W-1:0]  wr_data,
  input  wire          wr_block,
  output reg           wr_stall_reg,
  output wire [AW:0]   wr_level,
  input  wire          rd_clk,
  input  wire          rd_rst_n,
  input  wire          rd_pop,
  output wire [W-1:0]  rd_data,
  output reg           rd_empty_reg,
  output wire [AW:0]   rd_level
);

  localparam [AW:0] DEPTH = 1 << AW;

  function [AW:0] g2b;
    input [AW:0] g;
    integer i;
    begin
      g2b[AW] = g[AW];
      for (i = AW - 1; i >= 0; i = i - 1) begin
        g2b[i] = g2b[i + 1] ^ g[i];
      end
    end
  endfunction

  reg  [W-1:0] mem [0:(1<<AW)-1];
  reg  [AW:0]  wbin_reg;
  reg  [AW:0]  wgray_reg;
  reg  [AW:0]  rbin_reg;
  reg  [AW:0]  rgray_reg;
  reg  [AW:0]  rgray_s1_reg;
  reg  [AW:0]  rgray_s2_reg;
  reg  [AW:0]  wgray_s1_reg;
  reg  [AW:0]  wgray_s2_reg;

  // ----------------------------------------------------------------
  // Write side
  // ----------------------------------------------------------------
  wire         push       = wr_push & ~wr_stall_reg;
  wire [AW:0]  wbin_next  = wbin_reg + {{AW{1'b0}}, push};
  wire [AW:0]  rbin_w     = g2b(rgray_s2_reg);
  wire [AW:0]  wfill_next = wbin_next - rbin_w;

  assign wr_level = wbin_reg - rbin_w;

  always @(posedge wr_clk) begin
    if (push) begin
      mem[wbin_reg[AW-1:0]] <= wr_data;
    end
  end

  always @(posedge wr_clk or negedge wr_rst_n) begin
    if (!wr_rst_n) begin
      wbin_reg     <= {(AW+1){1'b0}};
      wgray_reg    <= {(AW+1){1'b0}};
      rgray_s1_reg <= {(AW+1){1'b0}};
      rgray_s2_reg <= {(AW+1){1'b0}};
      wr_stall_reg <= 1'b1;
    end else begin
      wbin_reg     <= wbin_next;
      wgray_reg    <= (wbin_next >> 1) ^ wbin_next;
      rgray_s1_reg <= rgray_reg;
      rgray_s2_reg <= rgray_s1_reg;
      // Stall one push early enough: flag reflects fill after this edge
      wr_stall_reg <= (wfill_next == DEPTH) | wr_block;
    end
  end

  // ----------------------------------------------------------------
  // Read side
  // ----------------------------------------------------------------
  wire         pop       = rd_pop & ~rd_empty_reg;
  wire [AW:0]  rbin_next = rbin_reg + {{AW{1'b0}}, pop};
  wire [AW:0]  wbin_r    = g2b(wgray_s2_reg);

  assign rd_data  = mem[rbin_reg[AW-1:0]];
  assign rd_level = wbin_r - rbin_reg;

  always @(posedge rd_clk or negedge rd_rst_n) begin
    if (!rd_rst_n) begin
      rbin_reg     <= {(AW+1){1'b0}};
      rgray_reg    <= {(AW+1){1'b0}};
      wgray_s1_reg <= {(AW+1){1'b0}};
      wgray_s2_reg <= {(AW+1){1'b0}};
      rd_empty_reg <= 1'b1;
    end else begin
      rbin_reg     <= rbin_next;
      rgray_reg    <= (rbin_next >> 1) ^ rbin_next;
      wgray_s1_reg <= wgray_reg;
      wgray_s2_reg <= wgray_s1_reg;
      rd_empty_reg <= (rbin_next == wbin_r);
    end
  end

endmodule // mcb_async_fifo

`default_nettype wire

// ### mcb_bridge.v
// Purpose: Memory-mapped clock-crossing bridge with APB status port.
// Assumes: Upstream port and APB share pclk; downstream runs on dn_clk.
// Notes:   Depths are powers of two; return depth is sized from the
//          forward depth, read latency and burst size.
`timescale 1ns/1ps
`default_nettype none
`include "mcb_map.vh"

// Notes on behaviour
// - One slave and one master port, pipelined, variable read latency.
// - Data width is a build parameter and sizes both FIFOs.
// - Bursts optional at build time; maximum length is a parameter.
// - Two independent FIFOs: commands forward, responses back.
// - Crossing never lets either FIFO overflow or underflow.
// - Forward entry: writedata, address, read, write, nativeaddress, byteenable, burstcount.
// - Return entry: readdata, readdatavalid, endofpacket from the downstream slave.
// - Each FIFO depth set by its own parameter.
// - Slave port flags readdatavalid in each cycle with returned data.
// - Slave port raises waitrequest when no room for another command.
// - Writes complete upstream once queued, without downstream acknowledge.
// - With bursts, incoming bursts pass through as bursts up to maximum.
// - Without bursts, burst length acts as one; upstream splits bursts.
// - No bursts: return depth at least forward depth plus max latency.
// - Bursts: return depth at least (forward depth plus latency) times burst.
// - Minimum return depth rounded up to a power of two.
// - With bursts, return FIFO absorbs all outstanding burst read data.
// - After first crossing, later transfers stream without added latency.
module mcb_bridge #(
  parameter DATA_W     = 32,
  parameter ADDR_W     = 16,
  parameter BURST_EN   = 1,
  parameter MAX_BURST  = 8,
  parameter BC_W       = 4,
  parameter FWD_AW     = 3,
  parameter RET_AW_REQ = 2,
  parameter MAX_LAT    = 4
) (
  input  wire                 pclk,
  input  wire                 presetn,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [7:0]           paddr,
  input  wire [31:0]          pwdata,
  output reg  [31:0]          prdata,
  output reg                  pready,
  output reg                  pslverr,
  input  wire [ADDR_W-1:0]    up_address,
  input  wire [ADDR_W-1:0]    up_nativeaddress,
  input  wire                 up_read,
  input  wire                 up_write,
  input  wire [DATA_W-1:0]    up_writedata,
  input  wire [DATA_W/8-1:0]  up_byteenable,
  input  wire [BC_W-1:0]      up_burstcount,
  output wire                 up_waitrequest,
  output reg  [DATA_W-1:0]    up_readdata,
  output reg                  up_readdatavalid,
  output reg                  up_endofpacket,
  input  wire                 dn_clk,
  input  wire                 dn_rst_n,
  output reg  [ADDR_W-1:0]    dn_address,
  output reg  [ADDR_W-1:0]    dn_nativeaddress,
  output reg                  dn_read,
  output reg                  dn_write,
  output reg  [DATA_W-1:0]    dn_writedata,
  output reg  [DATA_W/8-1:0]  dn_byteenable,
  output reg  [BC_W-1:0]      dn_burstcount,
  input  wire                 dn_waitrequest,
  input  wire [DATA_W-1:0]    dn_readdata,
  input  wire                 dn_readdatavalid,
  input  wire                 dn_endofpacket
);

  // ----------------------------------------------------------------
  // Sizing
  // ----------------------------------------------------------------
  function integer clog2;
    input integer v;
    integer r;
    begin
      r = 0;
      while ((1 << r) < v) begin
        r = r + 1;
      end
      clog2 = r;
    end
  endfunction

  localparam BE_W     = DATA_W / 8;
  localparam EFF_BST  = BURST_EN ? MAX_BURST : 1;
  localparam RET_MIN  = (((1 << FWD_AW) + MAX_LAT) * EFF_BST);
  localparam RET_REQ  = 1 << RET_AW_REQ;
  localparam RET_AW   = clog2((RET_MIN > RET_REQ) ? RET_MIN : RET_REQ);
  localparam BASE_W   = DATA_W + 2 * ADDR_W + BE_W + 2;
  localparam FW       = BASE_W + (BURST_EN ? BC_W : 0);
  localparam RW       = DATA_W + 2;
  localparam [RET_AW+1:0] RET_DV = 1 << RET_AW;

  // ----------------------------------------------------------------
  // Reset synchronisers
  // ----------------------------------------------------------------
  reg up_rst_s1_reg;
  reg up_rst_n_reg;
  reg dn_rst_s1_reg;
  reg dn_rst_n_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_rst_s1_reg <= 1'b0;
      up_rst_n_reg  <= 1'b0;
    end else begin
      up_rst_s1_reg <= 1'b1;
      up_rst_n_reg  <= up_rst_s1_reg;
    end
  end

  always @(posedge dn_clk or negedge dn_rst_n) begin
    if (!dn_rst_n) begin
      dn_rst_s1_reg <= 1'b0;
      dn_rst_n_reg  <= 1'b0;
    end else begin
      dn_rst_s1_reg <= 1'b1;
      dn_rst_n_reg  <= dn_rst_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Forward FIFO: upstream commands to downstream
  // ----------------------------------------------------------------
  reg                 enable_reg;
  wire                cmd_req  = up_read | up_write;
  wire                cmd_take = cmd_req & ~up_waitrequest;
  wire [BASE_W-1:0]   fwd_base = {up_nativeaddress, up_address, up_byteenable,
                                  up_writedata, up_write, up_read};
  wire [FW-1:0]       fwd_d;
  wire [FW-1:0]       fwd_q;
  wire [BC_W-1:0]     q_bc;
  wire                fwd_empty;
  wire [FWD_AW:0]     fwd_up_level;
  wire                fetch;

  generate
    if (BURST_EN) begin : g_bc
      assign fwd_d = {up_burstcount, fwd_base};
      assign q_bc  = fwd_q[FW-1 -: BC_W];
    end else begin : g_nbc
      assign fwd_d = fwd_base;
      assign q_bc  = {{(BC_W-1){1'b0}}, 1'b1};
    end
  endgenerate

  wire                q_read  = fwd_q[0];
  wire                q_write = fwd_q[1];
  wire [DATA_W-1:0]   q_wdata = fwd_q[2 +: DATA_W];
  wire [BE_W-1:0]     q_be    = fwd_q[2 + DATA_W +: BE_W];
  wire [ADDR_W-1:0]   q_addr  = fwd_q[2 + DATA_W + BE_W +: ADDR_W];
  wire [ADDR_W-1:0]   q_naddr = fwd_q[2 + DATA_W + BE_W + ADDR_W +: ADDR_W];

  // Waitrequest is the FIFO's registered stall flag
  mcb_async_fifo #(
    .W  (FW),
    .AW (FWD_AW)
  ) u_fwd_fifo (
    .wr_clk       (pclk),
    .wr_rst_n     (up_rst_n_reg),
    .wr_push      (cmd_take),
    .wr_data      (fwd_d),
    .wr_block     (~enable_reg),
    .wr_stall_reg (up_waitrequest),
    .wr_level     (fwd_up_level),
    .rd_clk       (dn_clk),
    .rd_rst_n     (dn_rst_n_reg),
    .rd_pop       (fetch),
    .rd_data      (fwd_q),
    .rd_empty_reg (fwd_empty),
    .rd_level     ()
  );

  // ----------------------------------------------------------------
  // Downstream master port
  // ----------------------------------------------------------------
  reg  [RET_AW:0]   out_beats_reg;
  wire [RET_AW:0]   ret_dn_level;
  wire              ret_stall;
  wire [RET_AW+1:0] need      = {1'b0, out_beats_reg} + {1'b0, ret_dn_level}
                              + {{(RET_AW+2-BC_W){1'b0}}, q_bc};
  wire              credit_ok = (need <= RET_DV);
  wire              slot_free = ~(dn_read | dn_write) | ~dn_waitrequest;
  wire [RET_AW:0]   bc_add    = (fetch & q_read) ? {{(RET_AW+1-BC_W){1'b0}}, q_bc}
                                                 : {(RET_AW+1){1'b0}};
  wire [RET_AW:0]   out_beats_next = out_beats_reg + bc_add
                                   - {{RET_AW{1'b0}}, dn_readdatavalid};

  // Reads wait until return room for their whole burst is reserved
  assign fetch = slot_free & ~fwd_empty & (~q_read | credit_ok);

  always @(posedge dn_clk or negedge dn_rst_n_reg) begin
    if (!dn_rst_n_reg) begin
      dn_address       <= {ADDR_W{1'b0}};
      dn_nativeaddress <= {ADDR_W{1'b0}};
      dn_read          <= 1'b0;
      dn_write         <= 1'b0;
      dn_writedata     <= {DATA_W{1'b0}};
      dn_byteenable    <= {BE_W{1'b0}};
      dn_burstcount    <= {{(BC_W-1){1'b0}}, 1'b1};
      out_beats_reg    <= {(RET_AW+1){1'b0}};
    end else begin
      out_beats_reg <= out_beats_next;
      if (fetch) begin
        dn_address       <= q_addr;
        dn_nativeaddress <= q_naddr;
        dn_read          <= q_read;
        dn_write         <= q_write;
        dn_writedata     <= q_wdata;
        dn_byteenable    <= q_be;
        dn_burstcount    <= q_bc;
      end else if (slot_free) begin
        dn_read  <= 1'b0;
        dn_write <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Return FIFO: downstream read data to upstream
  // ----------------------------------------------------------------
  wire [RW-1:0] ret_q;
  wire          ret_empty;
  wire [RET_AW:0] ret_up_level;

  mcb_async_fifo #(
    .W  (RW),
    .AW (RET_AW)
  ) u_ret_fifo (
    .wr_clk       (dn_clk),
    .wr_rst_n     (dn_rst_n_reg),
    .wr_push      (dn_readdatavalid),
    .wr_data      ({dn_endofpacket, dn_readdatavalid, dn_readdata}),
    .wr_block     (1'b0),
    .wr_stall_reg (ret_stall),
    .wr_level     (ret_dn_level),
    .rd_clk       (pclk),
    .rd_rst_n     (up_rst_n_reg),
    .rd_pop       (~ret_empty),
    .rd_data      (ret_q),
    .rd_empty_reg (ret_empty),
    .rd_level     (ret_up_level)
  );

  always @(posedge pclk or negedge up_rst_n_reg) begin
    if (!up_rst_n_reg) begin
      up_readdata      <= {DATA_W{1'b0}};
      up_readdatavalid <= 1'b0;
      up_endofpacket   <= 1'b0;
    end else begin
      up_readdata      <= ret_q[DATA_W-1:0];
      up_readdatavalid <= ~ret_empty & ret_q[DATA_W];
      up_endofpacket   <= ~ret_empty & ret_q[DATA_W+1];
    end
  end

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  reg  [31:0] rd_cnt_reg;
  reg  [31:0] wr_cnt_reg;
  reg  [31:0] status;
  reg  [31:0] rdata_next;
  reg         err_next;
  wire        setup   = psel & ~penable;
  wire        wr_acc  = psel & penable & pready & pwrite & ~pslverr;
  wire        clr_cnt = wr_acc & (paddr == `MCB_OFF_CTRL) & pwdata[`MCB_CTRL_CLRCNT];

  always @* begin
    status = 32'h0000_0000;
    status[`MCB_STAT_FWD_LSB +: FWD_AW+1] = fwd_up_level;
    status[`MCB_STAT_RET_LSB +: RET_AW+1] = ret_up_level;
    err_next   = 1'b0;
    rdata_next = 32'h0000_0000;
    case (paddr)
      `MCB_OFF_CTRL:   rdata_next = {31'h0000_0000, enable_reg};
      `MCB_OFF_STATUS: rdata_next = status;
      `MCB_OFF_RDCNT:  rdata_next = rd_cnt_reg;
      `MCB_OFF_WRCNT:  rdata_next = wr_cnt_reg;
      default:         err_next   = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge up_rst_n_reg) begin
    if (!up_rst_n_reg) begin
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      enable_reg <= `MCB_CTRL_RESET;
      rd_cnt_reg <= 32'h0000_0000;
      wr_cnt_reg <= 32'h0000_0000;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
        pslverr <= err_next;
      end else begin
        pslverr <= 1'b0;
      end
      if (wr_acc & (paddr == `MCB_OFF_CTRL)) begin
        enable_reg <= pwdata[`MCB_CTRL_ENABLE];
      end
      if (clr_cnt) begin
        rd_cnt_reg <= 32'h0000_0000;
        wr_cnt_reg <= 32'h0000_0000;
      end else begin
        rd_cnt_reg <= rd_cnt_reg + {31'h0000_0000, cmd_take & up_read};
        wr_cnt_reg <= wr_cnt_reg + {31'h0000_0000, cmd_take & up_write};
      end
    end
  end

endmodule // mcb_bridge

`default_nettype wire

// ### mcb_bridge_asserts.sv
// Purpose: Port assertions for the clock-crossing bridge.
// Assumes: Bound into mcb_bridge; two clock domains.
// Notes:   Read beats are counted against accepted reads.
`timescale 1ns/1ps
`default_nettype none
module mcb_bridge_asserts #(
  parameter ADDR_W    = 16,
  parameter BC_W      = 4,
  parameter BURST_EN  = 1,
  parameter MAX_BURST = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              up_read,
  input wire logic [BC_W-1:0]   up_burstcount,
  input wire logic              up_waitrequest,
  input wire logic              up_readdatavalid,
  input wire logic              up_endofpacket,
  input wire logic              dn_clk,
  input wire logic              dn_rst_n,
  input wire logic              dn_read,
  input wire logic              dn_write,
  input wire logic [ADDR_W-1:0] dn_address,
  input wire logic [BC_W-1:0]   dn_burstcount,
  input wire logic              dn_waitrequest
);
  // ----------------------------------------
  // Outstanding read beats
  // ----------------------------------------
  logic [9:0] outst_reg;
  logic [9:0] outst_next;
  always_comb begin
    outst_next = outst_reg - 10'(up_readdatavalid);
    if (up_read && !up_waitrequest)
      outst_next = outst_next + ((BURST_EN != 0) ? 10'(up_burstcount) : 10'h001);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      outst_reg <= 10'h000;
    else
      outst_reg <= outst_next;
  end
  sequence s_take;
    up_read && !up_waitrequest;
  endsequence
  sequence s_beat;
    ##[1:600] up_readdatavalid;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_beat_has_req: assert property (@(posedge pclk) disable iff (!presetn)
    up_readdatavalid |-> outst_reg != 10'h000) else $error("beat without read");
  a_eop_with_valid: assert property (@(posedge pclk) disable iff (!presetn)
    up_endofpacket |-> up_readdatavalid) else $error("eop without beat");
  a_wait_at_release: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> up_waitrequest) else $error("open at release");
  a_read_answered: assert property (@(posedge pclk) disable iff (!presetn)
    s_take |-> s_beat) else $error("read not answered");
  a_dn_idle_release: assert property (@(posedge dn_clk) disable iff (!dn_rst_n)
    $rose(dn_rst_n) |-> !dn_read && !dn_write) else $error("command at release");
  a_dn_cmd_hold: assert property (@(posedge dn_clk) disable iff (!dn_rst_n)
    (dn_read || dn_write) && dn_waitrequest |=> $stable({dn_read, dn_write, dn_address, dn_burstcount}))
    else $error("command dropped");
  a_dn_one_kind: assert property (@(posedge dn_clk) disable iff (!dn_rst_n)
    !(dn_read && dn_write)) else $error("read and write");
  a_burst_range: assert property (@(posedge dn_clk) disable iff (!dn_rst_n)
    (dn_read || dn_write) |-> dn_burstcount >= 1 && dn_burstcount <= ((BURST_EN != 0) ? MAX_BURST : 1))
    else $error("burst length");
endmodule // mcb_bridge_asserts
bind mcb_bridge mcb_bridge_asserts #(
  .ADDR_W(ADDR_W), .BC_W(BC_W), .BURST_EN(BURST_EN), .MAX_BURST(MAX_BURST)
) u_asserts (
  .pclk(pclk), .presetn(presetn), .up_read(up_read), .up_burstcount(up_burstcount),
  .up_waitrequest(up_waitrequest), .up_readdatavalid(up_readdatavalid), .up_endofpacket(up_endofpacket),
  .dn_clk(dn_clk), .dn_rst_n(dn_rst_n), .dn_read(dn_read), .dn_write(dn_write),
  .dn_address(dn_address), .dn_burstcount(dn_burstcount), .dn_waitrequest(dn_waitrequest)
);
`default_nettype wire

// ### mcb_bridge_bench.sv
// Purpose: Self-checking bench for the clock-crossing bridge.
// Assumes: Addresses are word indices of the slave model.
// Notes:   Downstream clock 14 ns, phase unrelated to pclk.
`timescale 1ns/1ps
`default_nettype none
`include "mcb_map.vh"
module mcb_bridge_bench;
  logic        pclk = 1'h0, dn_clk = 1'h0, presetn = 1'h0, dn_rst_n = 1'h0, e;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, up_writedata = 32'h0, prdata, q, up_readdata, dn_writedata, dn_readdata;
  logic [15:0] up_address = 16'h0000, dn_address, dn_naddr;
  logic        up_read = 1'h0, up_write = 1'h0, up_waitrequest, up_readdatavalid, up_endofpacket;
  logic [3:0]  up_byteenable = 4'hF, up_burstcount = 4'h1, dn_byteenable, dn_burstcount;
  logic        dn_read, dn_write, dn_waitrequest, dn_readdatavalid, dn_endofpacket;
  logic [1:0]  mode = 2'h0;
  logic [31:0] ref_mem [0:255];
  logic [31:0] got_d[$];
  logic        got_e[$];
  int          got_t[$];
  int          fails = 0, n_checks = 0, cyc = 0, stalls = 0;
  mcb_bridge u_mcb_bridge (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .up_address(up_address),
    .up_nativeaddress(~up_address), .up_read(up_read), .up_write(up_write), .up_writedata(up_writedata),
    .up_byteenable(up_byteenable), .up_burstcount(up_burstcount), .up_waitrequest(up_waitrequest),
    .up_readdata(up_readdata), .up_readdatavalid(up_readdatavalid), .up_endofpacket(up_endofpacket),
    .dn_clk(dn_clk), .dn_rst_n(dn_rst_n), .dn_address(dn_address), .dn_nativeaddress(dn_naddr),
    .dn_read(dn_read), .dn_write(dn_write), .dn_writedata(dn_writedata), .dn_byteenable(dn_byteenable),
    .dn_burstcount(dn_burstcount), .dn_waitrequest(dn_waitrequest), .dn_readdata(dn_readdata),
    .dn_readdatavalid(dn_readdatavalid), .dn_endofpacket(dn_endofpacket));
  mcb_slave_model u_mcb_slave_model (
    .dn_clk(dn_clk), .dn_rst_n(dn_rst_n), .mode(mode), .dn_address(dn_address), .dn_read(dn_read),
    .dn_write(dn_write), .dn_writedata(dn_writedata), .dn_byteenable(dn_byteenable),
    .dn_burstcount(dn_burstcount), .dn_waitrequest(dn_waitrequest), .dn_readdata(dn_readdata),
    .dn_readdatavalid(dn_readdatavalid), .dn_endofpacket(dn_endofpacket));
  initial forever #20 pclk = ~pclk;
  initial begin
    #3;
    forever #7 dn_clk = ~dn_clk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (up_readdatavalid === 1'h1) begin
      got_d.push_back(up_readdata);
      got_e.push_back(up_endofpacket);
      got_t.push_back(cyc);
    end
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  always @(posedge dn_clk)
    if ((dn_read | dn_write) === 1'h1 && dn_waitrequest === 1'h0)
      chk("naddr", {16'h0, ~dn_address}, {16'h0, dn_naddr});
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    {q, e} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask
  task automatic cmd(input logic r, input int a, input int off, input logic [31:0] d, input logic [3:0] be, bc);
    {up_read, up_write, up_address, up_writedata, up_byteenable, up_burstcount} <= {r, !r, 16'(a), d, be, bc};
    do begin
      @(posedge pclk);
      if (up_waitrequest !== 1'h0)
        stalls++;
    end while (up_waitrequest !== 1'h0);
    for (int b = 0; b < 4; b++)
      if (!r && be[b])
        ref_mem[a + off][8*b +: 8] = d[8*b +: 8];
  endtask
  task automatic idle();
    {up_read, up_write} <= 2'h0;
    @(posedge pclk);
  endtask
  task automatic beats(input int base, step, ncmd, bc, span);
    while (got_d.size() < ncmd * bc)
      @(negedge pclk);
    chk("beats", 32'(ncmd * bc), 32'(got_d.size()));
    for (int k = 0; k < got_d.size(); k++) begin
      chk("data", ref_mem[base + (k / bc) * step + k % bc], got_d[k]);
      chk("eop", 32'(k % bc == bc - 1), 32'(got_e[k]));
    end
    if (span > 0)
      chk("span", 32'h1, 32'(got_t[got_t.size() - 1] - got_t[0] <= span));
    got_d.delete();
    got_e.delete();
    got_t.delete();
    @(posedge pclk);
  endtask
  task automatic t_regs();
    apb(1'h0, `MCB_OFF_CTRL, 32'h0);
    chk("ctrl", {31'h0, `MCB_CTRL_RESET}, q);
    apb(1'h0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, q);
    apb(1'h1, `MCB_OFF_CTRL, 32'h0);
    repeat (4) @(posedge pclk);
    chk("wait_off", 32'h1, {31'h0, up_waitrequest});
    apb(1'h1, `MCB_OFF_CTRL, 32'h1);
  endtask
  task automatic t_write();
    int t0;
    mode <= 2'h2;
    t0 = cyc;
    for (int i = 0; i < 8; i++)
      cmd(1'h0, 16, i, 32'hC0DE0000 + i, 4'hF, 4'h8);
    chk("posted", 32'h1, 32'(cyc - t0 <= 20));
    mode <= 2'h0;
    cmd(1'h0, 32, 0, 32'hFFFFFFFF, 4'hF, 4'h1);
    cmd(1'h0, 32, 0, 32'h00001234, 4'h3, 4'h1);
    idle();
    cmd(1'h1, 16, 0, 32'h0, 4'hF, 4'h8);
    cmd(1'h1, 32, 0, 32'h0, 4'hF, 4'h1);
    idle();
    beats(16, 16, 1, 8, 0);
    beats(32, 0, 1, 1, 0);
  endtask
  task automatic t_stream();
    for (int i = 0; i < 8; i++)
      cmd(1'h1, 16 + i, 0, 32'h0, 4'hF, 4'h1);
    idle();
    beats(16, 1, 8, 1, 16);
  endtask
  task automatic t_fill();
    mode <= 2'h2;
    stalls = 0;
    fork
      for (int i = 0; i < 12; i++)
        cmd(1'h1, 16, 0, 32'h0, 4'hF, 4'h8);
      begin
        repeat (60) @(posedge pclk);
        mode <= 2'h1;
      end
    join
    idle();
    chk("stalled", 32'h1, 32'(stalls != 0));
    beats(16, 0, 12, 8, 0);
    apb(1'h0, `MCB_OFF_RDCNT, 32'h0);
    chk("rdcnt_all", 32'h16, q);
    apb(1'h0, `MCB_OFF_WRCNT, 32'h0);
    chk("wrcnt_all", 32'h0A, q);
    apb(1'h1, `MCB_OFF_CTRL, 32'h3);
    apb(1'h0, `MCB_OFF_RDCNT, 32'h0);
    chk("rdcnt", 32'h0, q);
    apb(1'h0, `MCB_OFF_STATUS, 32'h0);
    chk("levels", 32'h0, q);
    chk("extra", 32'h0, 32'(got_d.size()));
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    dn_rst_n <= 1'h1;
    repeat (3) @(posedge pclk);
    t_regs();
    t_write();
    t_stream();
    t_fill();
    results();
  end
endmodule // mcb_bridge_bench
`default_nettype wire

// ### mcb_map.vh
// Purpose: Shared constants of the clock-crossing bridge.
// Assumes: Included by its bare name; definitions only.
// Notes:   Offsets are byte addresses on the APB register port.
`ifndef MCB_MAP_VH
`define MCB_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MCB_OFF_CTRL    8'h00
`define MCB_OFF_STATUS  8'h04
`define MCB_OFF_RDCNT   8'h08
`define MCB_OFF_WRCNT   8'h0C

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define MCB_CTRL_ENABLE   0
`define MCB_CTRL_CLRCNT   1
`define MCB_CTRL_RESET    1'h1
`define MCB_STAT_FWD_LSB  0
`define MCB_STAT_RET_LSB  16

`endif

// ### mcb_slave_model.sv
// Purpose: Downstream slave with word memory.
// Assumes: mode 0 fast, 1 wait states and latency, 2 stalls commands.
// Notes:   Idle read data toggles so stale data cannot pass.
`timescale 1ns/1ps
`default_nettype none
module mcb_slave_model #(
  parameter LAT = 3
) (
  input  wire logic        dn_clk,
  input  wire logic        dn_rst_n,
  input  wire logic [1:0]  mode,
  input  wire logic [15:0] dn_address,
  input  wire logic        dn_read,
  input  wire logic        dn_write,
  input  wire logic [31:0] dn_writedata,
  input  wire logic [3:0]  dn_byteenable,
  input  wire logic [3:0]  dn_burstcount,
  output logic             dn_waitrequest,
  output logic [31:0]      dn_readdata,
  output logic             dn_readdatavalid,
  output logic             dn_endofpacket
);
  // ----------------------------------------
  // Slave behaviour
  // ----------------------------------------
  logic [31:0] mem [0:255];
  int          qa[$], qn[$], wb, rb, dly;
  logic        ph;
  always @(posedge dn_clk or negedge dn_rst_n) begin
    if (!dn_rst_n) begin
      {dn_waitrequest, dn_readdata, dn_readdatavalid, dn_endofpacket, ph} <= {1'h1, 32'h0, 3'h0};
      wb = 0;
      rb = 0;
      dly = 0;
      qa.delete();
      qn.delete();
    end else begin
      ph <= ~ph;
      dn_waitrequest <= mode[1] || (mode[0] && !ph);
      if (dn_write && !dn_waitrequest) begin
        for (int b = 0; b < 4; b++)
          if (dn_byteenable[b])
            mem[dn_address[7:0] + wb][8*b +: 8] = dn_writedata[8*b +: 8];
        wb = (wb + 1 < dn_burstcount) ? wb + 1 : 0;
      end
      if (dn_read && !dn_waitrequest) begin
        qa.push_back(dn_address[7:0]);
        qn.push_back(dn_burstcount);
      end
      {dn_readdatavalid, dn_endofpacket, dn_readdata} <= {2'h0, ~dn_readdata};
      if (qa.size() != 0 && dly < (mode == 2'h0 ? 0 : LAT))
        dly++;
      else if (qa.size() != 0 && !(mode[0] && ph)) begin
        dn_readdatavalid <= 1'h1;
        dn_endofpacket <= (rb + 1 == qn[0]);
        dn_readdata <= mem[qa[0] + rb];
        rb++;
        if (rb == qn[0]) begin
          rb = 0;
          dly = 0;
          void'(qa.pop_front());
          void'(qn.pop_front());
        end
      end
    end
  end
endmodule // mcb_slave_model
`default_nettype wire
